// file: core/bsst_status.sv
// Bridge split status register with mirrored primary bus number and captured device and function numbers
// How it works
// RL1: The split request delayed bit is not built and always reads zero.
// RL2: The split completion overrun bit is not built and always reads zero.
// RL3: An unmatched completion aimed at the bridge sets the unexpected completion flag.
// RL4: That flag holds until a one is written to it, ignores zero writes, and resets to zero.
// RL5: The discarded, fast clock and wide bus bits read as constant zero.
// RL6: The bus field reads back the primary bus number of the type 1 header.
// RL7: Every type 0 configuration write loads the device field from its device number.
// RL8: The function field reports the function number of the last type 0 access before the read itself.
// RL9: The completer ID is built from the stored bus, device and function numbers.
// RL10: The requester ID for forwarded transactions uses the same stored numbers.
// RL11: The upper ten reserved bits read as zero.
// RL12: Writes to read-only and reserved bits change nothing.
`timescale 1ns/1ns
`default_nettype none
`include "bsst_cfg.svh"
module bsst_status
  import bsst_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire bsst_cfg_req_type cfg_req,
  input wire logic [7:0] primary_bus,
  input wire logic unexpected_cpl,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output var bsst_id_type completer_id,
  output var bsst_id_type requester_id
);

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic hit_status(input bsst_cfg_req_type r);
    hit_status = r.valid && r.type0 && (r.offset == `BSST_STATUS_OFFSET);
  endfunction

  logic unexp_flag;
  logic next_unexp_flag;
  logic [4:0] captured_device_id;
  logic [4:0] next_captured_device_id;
  logic [2:0] captured_function_id;
  logic [2:0] next_captured_function_id;
  logic [31:0] next_rdata;
  logic next_rvalid;
  logic clear_unexp;
  logic [31:0] status_word;
  bsst_id_type next_completer_id;
  bsst_id_type next_requester_id;

  assign clear_unexp = hit_status(cfg_req) && cfg_req.write && cfg_req.be[2]
                       && cfg_req.wdata[`BSST_UNEXP_BIT];

  // ****************************************
  // Next state
  // ****************************************
  // Flag, captured numbers and read data
  always_comb begin
    next_unexp_flag = unexp_flag;
    if (clear_unexp) begin
      next_unexp_flag = 1'h0; // [RL4]
    end
    if (unexpected_cpl) begin
      next_unexp_flag = 1'h1; // Set wins over clear [RL3]
    end
    next_captured_device_id = captured_device_id;
    next_captured_function_id = captured_function_id;
    if (cfg_req.valid && cfg_req.type0) begin
      next_captured_function_id = cfg_req.func; // [RL8]
      if (cfg_req.write) begin
        next_captured_device_id = cfg_req.dev; // Any target register [RL7]
      end
    end
    status_word = 32'h0000_0000; // Reserved and unbuilt bits zero [RL1] [RL2] [RL5] [RL11]
    status_word[`BSST_UNEXP_BIT] = unexp_flag;
    status_word[`BSST_BUS_HI:`BSST_BUS_LO] = primary_bus; // [RL6]
    status_word[`BSST_DEV_HI:`BSST_DEV_LO] = captured_device_id;
    status_word[`BSST_FUNC_HI:`BSST_FUNC_LO] = captured_function_id;
    next_rvalid = hit_status(cfg_req) && !cfg_req.write;
    next_rdata = next_rvalid ? status_word : 32'h0000_0000; // Zero between answers
    // IDs follow the stored numbers one cycle late
    next_completer_id = {primary_bus, captured_device_id, captured_function_id}; // [RL9]
    next_requester_id = {primary_bus, captured_device_id, captured_function_id}; // [RL10]
  end

  // ****************************************
  // Registers
  // ****************************************
  // Write data touches only the flag [RL12]
  always_ff @(posedge mclk) begin
    if (rst) begin
      unexp_flag <= `BSST_FLAG_RESET; // [RL4]
      captured_device_id <= `BSST_DEV_RESET;
      captured_function_id <= `BSST_FUNC_RESET;
      cfg_rdata <= 32'h0000_0000;
      cfg_rvalid <= 1'h0;
      completer_id <= '0;
      requester_id <= '0;
    end else begin
      unexp_flag <= next_unexp_flag;
      captured_device_id <= next_captured_device_id;
      captured_function_id <= next_captured_function_id;
      cfg_rdata <= next_rdata;
      cfg_rvalid <= next_rvalid;
      completer_id <= next_completer_id; // [RL9]
      requester_id <= next_requester_id; // [RL10]
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Unmatched completion seen
  sequence s_unexp_event;
    unexpected_cpl;
  endsequence

  // Flag standing
  sequence s_flag_held;
    unexp_flag;
  endsequence

  // Write of one to the flag with no completion alongside
  sequence s_clear_write;
    clear_unexp && !unexpected_cpl;
  endsequence

  // Flag gone
  sequence s_flag_gone;
    !unexp_flag;
  endsequence

  // Read that hits this register
  sequence s_status_read;
    hit_status(cfg_req) && !cfg_req.write;
  endsequence

  // Answer standing on the read port
  sequence s_answer;
    cfg_rvalid;
  endsequence

  // Any unmatched completion sets the flag
  a_unexp_sets: assert property (@(posedge mclk) disable iff (rst) // [RL3]
    s_unexp_event |=> s_flag_held)
    else $error("unexpected completion did not set flag");

  // Completion and clear in one cycle leave the flag set
  a_set_wins: assert property (@(posedge mclk) disable iff (rst) // [RL3]
    (unexpected_cpl && clear_unexp) |=> s_flag_held)
    else $error("clear beat a simultaneous completion");

  // Flag holds until a one is written
  a_flag_sticky: assert property (@(posedge mclk) disable iff (rst) // [RL4]
    (unexp_flag && !clear_unexp) |=> unexp_flag)
    else $error("flag dropped without a write of one");

  // Write of one clears the flag
  a_flag_clears: assert property (@(posedge mclk) disable iff (rst) // [RL4]
    s_clear_write |=> s_flag_gone)
    else $error("write of one did not clear flag");

  // Reserved and unbuilt bits read zero
  a_fixed_zeros: assert property (@(posedge mclk) disable iff (rst) // [RL1] [RL2] [RL5] [RL11]
    cfg_rvalid |-> cfg_rdata[`BSST_RSVD_HI:`BSST_WIDE_BIT] ==
      {12'h000, cfg_rdata[`BSST_UNEXP_BIT], 3'h0})
    else $error("constant zero bits read nonzero");

  // Read shows the flag state
  a_read_flag: assert property (@(posedge mclk) disable iff (rst) // [RL4]
    cfg_rvalid |-> cfg_rdata[`BSST_UNEXP_BIT] == $past(unexp_flag))
    else $error("read flag does not match state");

  // Bus field mirrors the primary bus number
  a_bus_alias: assert property (@(posedge mclk) disable iff (rst) // [RL6]
    cfg_rvalid |-> cfg_rdata[`BSST_BUS_HI:`BSST_BUS_LO] == $past(primary_bus))
    else $error("bus field differs from primary bus");

  // Type 0 write loads the device number
  a_dev_capture: assert property (@(posedge mclk) disable iff (rst) // [RL7]
    (cfg_req.valid && cfg_req.type0 && cfg_req.write) |=> captured_device_id == $past(cfg_req.dev))
    else $error("device number not captured");

  // Device number untouched by anything else
  a_dev_hold: assert property (@(posedge mclk) disable iff (rst) // [RL12]
    !(cfg_req.valid && cfg_req.type0 && cfg_req.write) |=> $stable(captured_device_id))
    else $error("device number changed without a type 0 write");

  // Type 0 access loads the function number
  a_func_capture: assert property (@(posedge mclk) disable iff (rst) // [RL8]
    (cfg_req.valid && cfg_req.type0) |=> captured_function_id == $past(cfg_req.func))
    else $error("function number not captured");

  // Function number untouched by anything else
  a_func_hold: assert property (@(posedge mclk) disable iff (rst) // [RL8]
    !(cfg_req.valid && cfg_req.type0) |=> $stable(captured_function_id))
    else $error("function number changed without a type 0 access");

  // Completer ID built from the stored numbers
  a_cpl_build: assert property (@(posedge mclk) disable iff (rst) // [RL9]
    !$past(rst) |-> completer_id == {$past(primary_bus), $past(captured_device_id), $past(captured_function_id)})
    else $error("completer ID not built from stored numbers");

  // Requester ID built from the same numbers
  a_req_build: assert property (@(posedge mclk) disable iff (rst) // [RL10]
    !$past(rst) |-> requester_id == {$past(primary_bus), $past(captured_device_id), $past(captured_function_id)})
    else $error("requester ID not built from stored numbers");

  // ****************************************
  // Read port checks
  // ****************************************
  // Status read answered one cycle later
  a_read_answer: assert property (@(posedge mclk) disable iff (rst) // [RL6]
    s_status_read |=> s_answer)
    else $error("status read not answered");

  // Writes and other offsets get no answer
  a_no_answer: assert property (@(posedge mclk) disable iff (rst) // [RL12]
    !(hit_status(cfg_req) && !cfg_req.write) |=> !cfg_rvalid)
    else $error("answer without a status read");

  // Read data zero between answers
  a_rdata_idle: assert property (@(posedge mclk) disable iff (rst) // [RL11]
    !cfg_rvalid |-> cfg_rdata == 32'h0000_0000)
    else $error("read data nonzero without an answer");

endmodule
`default_nettype wire

// file: core/bsst_cfg.svh
// Offsets, field positions and reset values of the bridge split status register
`ifndef BSST_CFG_SVH
`define BSST_CFG_SVH
`define BSST_STATUS_OFFSET 12'h084
`define BSST_RSVD_HI 31
`define BSST_RSVD_LO 22
`define BSST_DELAYED_BIT 21
`define BSST_OVERRUN_BIT 20
`define BSST_UNEXP_BIT 19
`define BSST_DISCARD_BIT 18
`define BSST_FAST_BIT 17
`define BSST_WIDE_BIT 16
`define BSST_BUS_HI 15
`define BSST_BUS_LO 8
`define BSST_DEV_HI 7
`define BSST_DEV_LO 3
`define BSST_FUNC_HI 2
`define BSST_FUNC_LO 0
`define BSST_DEV_RESET 5'h00
`define BSST_FUNC_RESET 3'h0
`define BSST_FLAG_RESET 1'h0
`endif

// file: core/bsst_pkg.sv
// Types shared by the bridge split status register
`default_nettype none
package bsst_pkg;
  // Configuration request as seen from the primary side
  typedef struct packed {
    logic valid;
    logic write;
    logic type0;
    logic [11:0] offset;
    logic [4:0] dev;
    logic [2:0] func;
    logic [31:0] wdata;
    logic [3:0] be;
  } bsst_cfg_req_type;

  // Bus, device and function numbers forming an ID
  typedef struct packed {
    logic [7:0] bus;
    logic [4:0] dev;
    logic [2:0] func;
  } bsst_id_type;
endpackage
`default_nettype wire

// file: test/bsst_upstream.sv
// Upstream requester model issuing configuration accesses
`timescale 1ns/1ns
`default_nettype none
module bsst_upstream
  import bsst_pkg::*;
(
  input wire logic mclk,
  output var bsst_cfg_req_type cfg_req
);
  // Byte enables of the next request
  logic [3:0] lanes = 4'hF;
  // ****************
  // Request driver
  // ****************
  initial cfg_req = '0;
  // One-cycle request, then fields scrambled so no stale value lingers
  task automatic send(input logic wr, input logic t0, input logic [11:0] off,
    input logic [4:0] dv, input logic [2:0] fn, input logic [31:0] wd);
    bsst_cfg_req_type r;
    r = '{1'h1, wr, t0, off, dv, fn, wd, lanes};
    @(posedge mclk);
    cfg_req <= r;
    @(posedge mclk);
    r = ~r;
    r.valid = 1'h0;
    cfg_req <= r;
  endtask
endmodule
`default_nettype wire

// file: test/bsst_status_bench.sv
// Self-checking bench for the bridge split status register
`timescale 1ns/1ns
`default_nettype none
module bsst_status_bench;
  import bsst_pkg::*;
  // ****************
  // Signals and rows
  // ****************
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic unexpected_cpl = 1'h0;
  logic [7:0] primary_bus = 8'h00;
  logic cfg_rvalid;
  logic [31:0] cfg_rdata;
  bsst_cfg_req_type cfg_req;
  bsst_id_type completer_id;
  bsst_id_type requester_id;
  int bad_count = 0;
  int compares = 0;
  int n;
  logic [7:0] b;
  logic [4:0] d;
  logic [2:0] f;
  logic [11:0] o;
  logic [31:0] w;
  // Bus, device, function, write offset, write data
  logic [59:0] rows [4] = '{60'h00FF084FFF7FFFF, 60'hFF0000000000000,
    60'h5AADFFCA5A5A5A5, 60'h015208800080000};
  initial forever #2 mclk = ~mclk;
  bsst_upstream bsst_upstream_i(.mclk(mclk), .cfg_req(cfg_req));
  bsst_status bsst_status_i(.mclk(mclk), .rst(rst), .cfg_req(cfg_req),
    .primary_bus(primary_bus), .unexpected_cpl(unexpected_cpl), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .completer_id(completer_id), .requester_id(requester_id));
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Status read; answer expected on the same edge that takes it
  task automatic rd(input logic [2:0] fn, input logic [31:0] e);
    n = 1;
    bsst_upstream_i.send(1'h0, 1'h1, 12'h084, 5'h00, fn, 32'h0);
    #1;
    while (cfg_rvalid !== 1'h1 && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("rdata", e, cfg_rdata);
    chk("delay", 1, n);
    if (cfg_rvalid !== 1'h1) end_sim;
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'h0;
    rd(3'h0, 32'h0);
    foreach (rows[i]) begin
      {b, d, f, o, w} = rows[i];
      @(posedge mclk);
      primary_bus <= b;
      bsst_upstream_i.send(1'h1, 1'h1, o, d, f, w);
      rd(f, {16'h0, b, d, f});
      chk("cpl_id", {b, d, f}, completer_id);
      chk("req_id", {b, d, f}, requester_id);
      $display("row %0d done", i);
    end
    @(posedge mclk);
    unexpected_cpl <= 1'h1;
    @(posedge mclk);
    unexpected_cpl <= 1'h0;
    bsst_upstream_i.send(1'h1, 1'h1, 12'h084, 5'h0A, 3'h2, 32'hFFF7FFFF);
    rd(3'h2, 32'h00080152);
    bsst_upstream_i.send(1'h1, 1'h0, 12'h084, 5'h1F, 3'h2, 32'h00080000);
    rd(3'h2, 32'h00080152);
    bsst_upstream_i.send(1'h1, 1'h1, 12'h084, 5'h0A, 3'h2, 32'h00080000);
    rd(3'h2, 32'h00000152);
    // Completion and clear in one cycle, then a clear without lane 2
    @(posedge mclk);
    unexpected_cpl <= 1'h1;
    bsst_upstream_i.send(1'h1, 1'h1, 12'h084, 5'h0A, 3'h2, 32'h00080000);
    unexpected_cpl <= 1'h0;
    rd(3'h2, 32'h00080152);
    bsst_upstream_i.lanes = 4'hB;
    bsst_upstream_i.send(1'h1, 1'h1, 12'h084, 5'h0A, 3'h2, 32'h00080000);
    bsst_upstream_i.lanes = 4'hF;
    rd(3'h2, 32'h00080152);
    // Read of another offset: no answer, function number still taken
    bsst_upstream_i.send(1'h0, 1'h1, 12'h088, 5'h00, 3'h1, 32'h0);
    #1;
    chk("no_answer", 0, cfg_rvalid);
    chk("idle_data", 0, cfg_rdata);
    rd(3'h2, 32'h00080151);
    $display("flag test done");
    // Reset in mid-run clears flag and captured numbers
    @(posedge mclk);
    rst <= 1'h1;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    rd(3'h3, 32'h00000100);
    chk("cpl_id", 32'h00000100, completer_id);
    $display("reset test done");
    end_sim;
  end
endmodule
`default_nettype wire
